// File: include/sfspi_defines.svh
// constants of the serial flash front end: offsets, reset values, opcodes, timing
`ifndef SFSPI_DEFINES_SVH
`define SFSPI_DEFINES_SVH

// ==========================================
// register offsets and reset values
`define SFSPI_CTRL_OFS 8'h00
`define SFSPI_STAT_OFS 8'h04
`define SFSPI_EVT_OFS 8'h08
`define SFSPI_CTRL_RST 1'h1

// ==========================================
// command opcodes
`define SFSPI_OP_NONE 8'h00
`define SFSPI_OP_WRSR 8'h01
`define SFSPI_OP_PP 8'h02
`define SFSPI_OP_READ 8'h03
`define SFSPI_OP_WRDI 8'h04
`define SFSPI_OP_RDSR 8'h05
`define SFSPI_OP_WREN 8'h06
`define SFSPI_OP_BE 8'hC7
`define SFSPI_OP_SE 8'hD8

// ==========================================
// array geometry and timing
`define SFSPI_PAGE_AW 8
`define SFSPI_SECT_AW 16
`define SFSPI_MEM_AW 22
`define SFSPI_ERASED 8'hFF
`define SFSPI_CLK_NS 4
`define SFSPI_WRSR_NS 2000

`endif

// File: include/sfspi_pkg.sv
// types shared by the serial flash front end
package sfspi_pkg;

  // synchronised pin group, msb first as concatenated at the top
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic hold_n;
    logic wp_n;
    logic din;
  } sfspi_pins_t;

  // status byte as shifted out by the status read command
  typedef struct packed {
    logic srwd;
    logic [1:0] pad;
    logic [2:0] bp;
    logic write_enable_latch;
    logic wip;
  } sfspi_sr_t;

  typedef enum logic [2:0] {F_CMD, F_ADDR, F_DATA_IN, F_DATA_OUT, F_SKIP} sfspi_frame_t;

  typedef enum logic [2:0] {K_NONE, K_WREN, K_WRDI, K_WRSR, K_PP, K_SE, K_BE} sfspi_kind_t;

endpackage

// File: design/sfspi_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
module sfspi_sync #(
  parameter int W = 5
) (
  input wire logic clk_i, // core clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic [W-1:0] d_i, // asynchronous pins
  output logic [W-1:0] q_o // synchronised pins
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  generate
    if (W < 1) begin : g_bad
      $error("sfspi_sync: W must be at least 1");
    end
  endgenerate

  // the first stage feeds the second stage only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule

// File: design/sfspi_top.sv
// serial flash front end: spi slave, array with program/erase engine, ahb-lite registers
// ==========================================
// Function
// - output bit shifted onto serial_out_line after falling sclk edges
// - serial_in_line sampled on rising sclk edges
// - select high deselects and releases serial_out_line
// - deselected and idle means standby; internal cycle keeps it active
// - select low activates the device ready for a command
// - no command accepted before a first select falling edge
// - pause releases output and ignores clock and input
// - write-protect asserted freezes the block-protect bits
// - modes 0 and 3: sample on rise, drive from fall
// - page program takes 1 to 256 bytes within one page
// - 64 sectors of 256 pages of 256 bytes
// - bulk erase and sector erase, no page erase
// - pause starts and ends only while sclk is low
// - select rising during pause resets interface, drops command
// - program/erase/status write need whole bytes and write enable
// - pause does not abort a running internal cycle
`timescale 1ns/1ps
`include "sfspi_defines.svh"
module sfspi_top #(
  parameter int MEM_AW = `SFSPI_MEM_AW,
  parameter int WRSR_NS = `SFSPI_WRSR_NS
) (
  input wire logic clk_i, // core clock, 250 MHz
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic hsel_i, // ahb slave select
  input wire logic [31:0] haddr_i, // ahb address
  input wire logic [1:0] htrans_i, // ahb transfer type
  input wire logic hwrite_i, // ahb write
  input wire logic [2:0] hsize_i, // ahb size, word only
  input wire logic [31:0] hwdata_i, // ahb write data
  input wire logic hready_i, // ahb bus ready
  output logic hreadyout_o, // ahb slave ready
  output logic hresp_o, // ahb response, always okay
  output logic [31:0] hrdata_o, // ahb read data
  input wire logic spi_sclk_i, // serial clock pin
  input wire logic spi_cs_n_i, // select pin, active low
  input wire logic spi_hold_n_i, // pause pin, active low
  input wire logic spi_wp_n_i, // write-protect pin, active low
  input wire logic serial_in_line_i, // serial data in
  output logic serial_out_line_o, // serial data out
  output logic serial_out_line_oe_o, // serial out driven when high
  output logic standby_o // device in standby power
);
  localparam int WRSR_CYC_I = (WRSR_NS + `SFSPI_CLK_NS - 1) / `SFSPI_CLK_NS;
  localparam logic [15:0] WRSR_CYC = 16'(WRSR_CYC_I);
  localparam int MEM_BYTES = 1 << MEM_AW;
  localparam int PAGE_B = 1 << `SFSPI_PAGE_AW;

  generate
    if (MEM_AW < 17 || MEM_AW > 22) begin : g_bad_aw
      $error("sfspi_top: MEM_AW must lie in 17..22");
    end
    if (WRSR_CYC_I < 1 || WRSR_CYC_I > 65535) begin : g_bad_wrsr
      $error("sfspi_top: WRSR_NS out of range");
    end
  endgenerate

  // ==========================================
  // functions
  function automatic logic prot_hit(input logic [2:0] bp, input logic [5:0] sec);
    logic [6:0] lim;
    lim = 7'h40 - (7'h01 << (bp - 3'h1));
    prot_hit = (bp != 3'h0) && ({1'b0, sec} >= lim);
  endfunction

  function automatic sfspi_pkg::sfspi_kind_t cmd_kind(input logic [7:0] op, input logic [1:0] ab,
                                                       input logic [8:0] n);
    cmd_kind = sfspi_pkg::K_NONE;
    if (op == `SFSPI_OP_WREN) begin
      cmd_kind = sfspi_pkg::K_WREN;
    end else if (op == `SFSPI_OP_WRDI) begin
      cmd_kind = sfspi_pkg::K_WRDI;
    end else if (op == `SFSPI_OP_WRSR && n != 9'h000) begin
      cmd_kind = sfspi_pkg::K_WRSR;
    end else if (op == `SFSPI_OP_PP && ab == 2'h3 && n != 9'h000) begin
      cmd_kind = sfspi_pkg::K_PP;
    end else if (op == `SFSPI_OP_SE && ab == 2'h3) begin
      cmd_kind = sfspi_pkg::K_SE;
    end else if (op == `SFSPI_OP_BE) begin
      cmd_kind = sfspi_pkg::K_BE;
    end
  endfunction

  // ==========================================
  // storage and state
  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] pb_q [PAGE_B];

  sfspi_pkg::sfspi_pins_t pin_raw;
  sfspi_pkg::sfspi_pins_t pin_s;
  sfspi_pkg::sfspi_frame_t st_reg;
  sfspi_pkg::sfspi_kind_t kind_reg;
  sfspi_pkg::sfspi_kind_t ex_reg;
  sfspi_pkg::sfspi_sr_t sr_new_reg;
  sfspi_pkg::sfspi_sr_t sr;

  logic sclk_reg, cs_n_reg, hold_reg, armed_reg, frame_ok_reg, ctrl_en_reg;
  logic [7:0] sh_reg, op_reg, tx_reg, last_op_reg, rej_reg;
  logic [7:0] sh_next;
  logic [2:0] bit_reg, bp_reg;
  logic [1:0] ab_reg;
  logic [23:0] addr_reg, go_addr_reg;
  logic [8:0] pb_cnt_reg, go_n_reg;
  logic go_reg, wel_reg, srwd_reg;
  logic [MEM_AW-1:0] ex_a_reg, rd_idx;
  logic [8:0] ex_i_reg;
  logic [15:0] cnt_reg;
  logic [7:0] wr_ofs_reg;
  logic wr_pend_reg;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, shift_en, busy;

  assign pin_raw = {spi_sclk_i, spi_cs_n_i, spi_hold_n_i, spi_wp_n_i, serial_in_line_i};

  sfspi_sync #(.W($bits(sfspi_pkg::sfspi_pins_t))) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  assign sclk_rise = pin_s.sclk & ~sclk_reg;
  assign sclk_fall = ~pin_s.sclk & sclk_reg;
  assign cs_fall = ~pin_s.cs_n & cs_n_reg;
  assign cs_rise = pin_s.cs_n & ~cs_n_reg;
  assign shift_en = ~pin_s.cs_n & frame_ok_reg & ~hold_reg;
  assign sh_next = {sh_reg[6:0], pin_s.din};
  assign busy = (ex_reg != sfspi_pkg::K_NONE);
  assign sr = '{srwd: srwd_reg, pad: 2'h0, bp: bp_reg, write_enable_latch: wel_reg, wip: busy};
  assign rd_idx = addr_reg[MEM_AW-1:0];

  // ==========================================
  // pin edges, pause and power state
  // cs_n_reg resets low so a select already low at reset is not an edge
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b0;
      hold_reg <= 1'b0;
      armed_reg <= 1'b0;
      standby_o <= 1'b0;
    end else begin
      sclk_reg <= pin_s.sclk;
      cs_n_reg <= pin_s.cs_n;
      if (cs_fall) begin
        armed_reg <= 1'b1;
      end
      if (pin_s.cs_n) begin
        hold_reg <= 1'b0;
      end else if (!pin_s.sclk) begin
        hold_reg <= ~pin_s.hold_n;
      end
      standby_o <= pin_s.cs_n & ~busy;
    end
  end

  // ==========================================
  // serial frame: command, address, data
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_reg <= sfspi_pkg::F_CMD;
      frame_ok_reg <= 1'b0;
      sh_reg <= 8'h00;
      bit_reg <= 3'h0;
      ab_reg <= 2'h0;
      op_reg <= `SFSPI_OP_NONE;
      addr_reg <= 24'h000000;
      pb_cnt_reg <= 9'h000;
      tx_reg <= 8'h00;
      sr_new_reg <= '0;
    end else if (pin_s.cs_n) begin
      st_reg <= sfspi_pkg::F_CMD;
      frame_ok_reg <= 1'b0;
      bit_reg <= 3'h0;
      ab_reg <= 2'h0;
      pb_cnt_reg <= 9'h000;
    end else begin
      if (cs_fall) begin
        // a select taken while paused stays dead until the next frame
        frame_ok_reg <= pin_s.hold_n & ctrl_en_reg;
      end
      if (shift_en && sclk_rise) begin
        sh_reg <= sh_next;
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'h7) begin
          case (st_reg)
            sfspi_pkg::F_CMD: begin
              if (busy && sh_next != `SFSPI_OP_RDSR) begin
                op_reg <= `SFSPI_OP_NONE;
                st_reg <= sfspi_pkg::F_SKIP;
              end else begin
                op_reg <= sh_next;
                if (sh_next == `SFSPI_OP_RDSR) begin
                  tx_reg <= sr;
                  st_reg <= sfspi_pkg::F_DATA_OUT;
                end else if (sh_next == `SFSPI_OP_READ || sh_next == `SFSPI_OP_PP
                             || sh_next == `SFSPI_OP_SE) begin
                  st_reg <= sfspi_pkg::F_ADDR;
                end else if (sh_next == `SFSPI_OP_WRSR) begin
                  st_reg <= sfspi_pkg::F_DATA_IN;
                end else begin
                  st_reg <= sfspi_pkg::F_SKIP;
                end
              end
            end
            sfspi_pkg::F_ADDR: begin
              addr_reg <= {addr_reg[15:0], sh_next};
              ab_reg <= ab_reg + 2'h1;
              if (ab_reg == 2'h2) begin
                if (op_reg == `SFSPI_OP_READ) begin
                  tx_reg <= mem_q[{addr_reg[MEM_AW-9:0], sh_next}];
                  addr_reg <= {addr_reg[15:0], sh_next} + 24'h000001;
                  st_reg <= sfspi_pkg::F_DATA_OUT;
                end else if (op_reg == `SFSPI_OP_PP) begin
                  st_reg <= sfspi_pkg::F_DATA_IN;
                end else begin
                  st_reg <= sfspi_pkg::F_SKIP;
                end
              end
            end
            sfspi_pkg::F_DATA_IN: begin
              // beyond one page every later byte lands in entry 0 and the last one wins
              if (op_reg == `SFSPI_OP_WRSR) begin
                if (pb_cnt_reg == 9'h000) begin
                  sr_new_reg <= sh_next;
                end
              end else begin
                pb_q[pb_cnt_reg[7:0]] <= sh_next;
              end
              if (pb_cnt_reg != 9'(PAGE_B)) begin
                pb_cnt_reg <= pb_cnt_reg + 9'h001;
              end
            end
            sfspi_pkg::F_DATA_OUT: begin
              if (op_reg == `SFSPI_OP_RDSR) begin
                tx_reg <= sr;
              end else begin
                tx_reg <= mem_q[rd_idx];
                addr_reg <= addr_reg + 24'h000001;
              end
            end
            default: begin
              st_reg <= sfspi_pkg::F_SKIP;
            end
          endcase
        end
      end else if (shift_en && sclk_fall && st_reg == sfspi_pkg::F_DATA_OUT) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // ==========================================
  // end of frame: whole bytes only, no pause at deselect
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      go_reg <= 1'b0;
      kind_reg <= sfspi_pkg::K_NONE;
      go_addr_reg <= 24'h000000;
      go_n_reg <= 9'h000;
      last_op_reg <= `SFSPI_OP_NONE;
      rej_reg <= 8'h00;
    end else begin
      go_reg <= cs_rise & frame_ok_reg & ~hold_reg & (bit_reg == 3'h0);
      kind_reg <= cmd_kind(op_reg, ab_reg, pb_cnt_reg);
      go_addr_reg <= addr_reg;
      if (cs_rise && !busy) begin
        go_n_reg <= pb_cnt_reg;
      end
      if (cs_rise && frame_ok_reg) begin
        last_op_reg <= op_reg;
        if (bit_reg != 3'h0 && rej_reg != 8'hFF) begin
          rej_reg <= rej_reg + 8'h01;
        end
      end
    end
  end

  // ==========================================
  // internal cycle engine and status bits
  // the engine runs from the core clock alone, so pause cannot stop it
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ex_reg <= sfspi_pkg::K_NONE;
      wel_reg <= 1'b0;
      bp_reg <= 3'h0;
      srwd_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      ex_a_reg <= '0;
      ex_i_reg <= 9'h000;
    end else if (!busy) begin
      if (go_reg) begin
        case (kind_reg)
          sfspi_pkg::K_WREN: begin
            wel_reg <= 1'b1;
          end
          sfspi_pkg::K_WRDI: begin
            wel_reg <= 1'b0;
          end
          sfspi_pkg::K_WRSR: begin
            if (wel_reg) begin
              ex_reg <= sfspi_pkg::K_WRSR;
              cnt_reg <= WRSR_CYC;
              if (pin_s.wp_n) begin
                bp_reg <= sr_new_reg.bp;
                srwd_reg <= sr_new_reg.srwd;
              end
            end
          end
          sfspi_pkg::K_PP: begin
            if (wel_reg && !prot_hit(bp_reg, go_addr_reg[21:16])) begin
              ex_reg <= sfspi_pkg::K_PP;
              ex_a_reg <= go_addr_reg[MEM_AW-1:0];
              ex_i_reg <= 9'h000;
            end
          end
          sfspi_pkg::K_SE: begin
            if (wel_reg && !prot_hit(bp_reg, go_addr_reg[21:16])) begin
              ex_reg <= sfspi_pkg::K_SE;
              ex_a_reg <= {go_addr_reg[MEM_AW-1:`SFSPI_SECT_AW], 16'h0000};
            end
          end
          sfspi_pkg::K_BE: begin
            if (wel_reg && bp_reg == 3'h0) begin
              ex_reg <= sfspi_pkg::K_BE;
              ex_a_reg <= '0;
            end
          end
          default: begin
            ex_reg <= sfspi_pkg::K_NONE;
          end
        endcase
      end
    end else begin
      case (ex_reg)
        sfspi_pkg::K_WRSR: begin
          cnt_reg <= cnt_reg - 16'h0001;
          if (cnt_reg == 16'h0001) begin
            ex_reg <= sfspi_pkg::K_NONE;
            wel_reg <= 1'b0;
          end
        end
        sfspi_pkg::K_PP: begin
          // column wraps inside the page, never into the next one
          mem_q[{ex_a_reg[MEM_AW-1:8], ex_a_reg[7:0] + ex_i_reg[7:0]}] <=
            mem_q[{ex_a_reg[MEM_AW-1:8], ex_a_reg[7:0] + ex_i_reg[7:0]}] & pb_q[ex_i_reg[7:0]];
          ex_i_reg <= ex_i_reg + 9'h001;
          if (ex_i_reg == go_n_reg - 9'h001) begin
            ex_reg <= sfspi_pkg::K_NONE;
            wel_reg <= 1'b0;
          end
        end
        default: begin
          mem_q[ex_a_reg] <= `SFSPI_ERASED;
          ex_a_reg <= ex_a_reg + 1'b1;
          if ((ex_reg == sfspi_pkg::K_SE && ex_a_reg[15:0] == 16'hFFFF) || (&ex_a_reg)) begin
            ex_reg <= sfspi_pkg::K_NONE;
            wel_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================
  // serial output pin
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      serial_out_line_o <= 1'b0;
      serial_out_line_oe_o <= 1'b0;
    end else begin
      serial_out_line_oe_o <= shift_en & (st_reg == sfspi_pkg::F_DATA_OUT);
      if (shift_en && sclk_fall && st_reg == sfspi_pkg::F_DATA_OUT) begin
        serial_out_line_o <= tx_reg[7];
      end
    end
  end

  // ==========================================
  // ahb-lite slave, zero wait states
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      ctrl_en_reg <= `SFSPI_CTRL_RST;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (wr_pend_reg && wr_ofs_reg == `SFSPI_CTRL_OFS) begin
        ctrl_en_reg <= hwdata_i[0];
      end
      if (hready_i) begin
        wr_pend_reg <= hsel_i & htrans_i[1] & hwrite_i;
        wr_ofs_reg <= haddr_i[7:0];
        if (hsel_i && htrans_i[1] && !hwrite_i) begin
          if (haddr_i[7:0] == `SFSPI_CTRL_OFS) begin
            hrdata_o <= {31'h00000000, ctrl_en_reg};
          end else if (haddr_i[7:0] == `SFSPI_STAT_OFS) begin
            hrdata_o <= {19'h00000, busy, armed_reg, pin_s.cs_n & ~busy, hold_reg, ~pin_s.cs_n, sr};
          end else if (haddr_i[7:0] == `SFSPI_EVT_OFS) begin
            hrdata_o <= {16'h0000, rej_reg, last_op_reg};
          end else begin
            hrdata_o <= 32'h00000000;
          end
        end
      end
    end
  end

endmodule

// File: test/sfspi_top_sva.sv
// assertion checker for the serial flash front end pins
`timescale 1ns/1ps
// ==========================================
// checker
module sfspi_top_sva (
  input wire logic clk_i, // core clock
  input wire logic rstn_i, // reset, active low
  input wire logic hreadyout_o, // ahb ready
  input wire logic hresp_o, // ahb response
  input wire logic spi_sclk_i, // serial clock pin
  input wire logic spi_cs_n_i, // select pin, active low
  input wire logic spi_hold_n_i, // pause pin, active low
  input wire logic serial_out_line_o, // serial data out
  input wire logic serial_out_line_oe_o, // serial out enable
  input wire logic standby_o // standby flag
);
  logic sclk_q;
  logic [3:0] since_fall;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // cycles since the raw clock pin fell; saturates so long gaps never wrap
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
      since_fall <= 4'hF;
    end else begin
      sclk_q <= spi_sclk_i;
      if (sclk_q && !spi_sclk_i) begin
        since_fall <= 4'h1;
      end else if (since_fall != 4'hF) begin
        since_fall <= since_fall + 4'h1;
      end
    end
  end
  a_oe_off_desel: assert property (spi_cs_n_i [*6] |-> !serial_out_line_oe_o)
    else $error("serial out driven while deselected");
  a_frame_end_off: assert property ($rose(spi_cs_n_i) |-> ##[1:8] !serial_out_line_oe_o)
    else $error("serial out not released after select rose");
  a_oe_off_pause: assert property ((!spi_hold_n_i && !spi_sclk_i) [*6] |-> !serial_out_line_oe_o)
    else $error("serial out driven during pause");
  a_oe_rise_sel: assert property ($rose(serial_out_line_oe_o) |-> !spi_cs_n_i && spi_hold_n_i)
    else $error("serial out enabled outside an active frame");
  a_out_after_fall: assert property (serial_out_line_oe_o && $past(serial_out_line_oe_o)
    && $changed(serial_out_line_o) |-> since_fall >= 4'h2 && since_fall <= 4'h6)
    else $error("serial out changed away from a clock fall");
  a_out_hold_high: assert property ((spi_sclk_i && serial_out_line_oe_o) [*8] |-> $stable(serial_out_line_o))
    else $error("serial out changed while clock high");
  a_active_sel: assert property (!spi_cs_n_i [*5] |-> !standby_o)
    else $error("standby while selected");
  a_ready_okay: assert property ($past(rstn_i) |-> hreadyout_o && !hresp_o)
    else $error("bus not ready or response not okay");
endmodule

bind sfspi_top sfspi_top_sva i_sva (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .spi_sclk_i(spi_sclk_i),
  .spi_cs_n_i(spi_cs_n_i),
  .spi_hold_n_i(spi_hold_n_i),
  .serial_out_line_o(serial_out_line_o),
  .serial_out_line_oe_o(serial_out_line_oe_o),
  .standby_o(standby_o)
);

// File: test/sfspi_master_model.sv
// behavioural serial bus master that faces the flash front end
`timescale 1ns/1ps
// ==========================================
// master model
module sfspi_master_model (
  input wire logic clk_i, // core clock, paces the link
  input wire logic serial_out_line_i, // device serial out
  input wire logic serial_out_line_oe_i, // device drives serial out
  output logic sclk_o, // serial clock
  output logic cs_n_o, // select, active low
  output logic hold_n_o, // pause, active low
  output logic wp_n_o, // write protect, active low
  output logic din_o // serial data to device
);
  localparam int HALF = 20; // 168 ns link period (21 cycles per half), far below the clock ceiling
  logic cpol = 1'b0;
  int pause_bit = -1;
  logic [7:0] rx_q[$];
  logic last_q = 1'b0;
  logic line;
  // a released line has no pull: show the inverse of the last driven level
  assign line = serial_out_line_oe_i ? serial_out_line_i : ~last_q;
  always @(posedge clk_i) begin
    if (serial_out_line_oe_i) begin
      last_q <= serial_out_line_i;
    end
  end
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    hold_n_o = 1'b1;
    wp_n_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic half_wait();
    repeat (HALF) @(posedge clk_i);
  endtask
  // pause with the clock low, toggle clock and data meanwhile, then resume
  task automatic pause_hold(input logic b);
    @(posedge clk_i) hold_n_o <= 1'b0; // only while selected and clock low
    half_wait();
    repeat (2) begin
      @(posedge clk_i) begin
        sclk_o <= 1'b1;
        din_o <= ~din_o;
      end
      half_wait();
      @(posedge clk_i) sclk_o <= 1'b0;
      half_wait();
    end
    @(posedge clk_i) begin
      hold_n_o <= 1'b1;
      din_o <= b;
    end
    half_wait();
  endtask
  task automatic frame(input logic [7:0] tx[$], input int nbits);
    logic [7:0] rx;
    logic b;
    rx_q.delete();
    rx = 8'h00;
    @(posedge clk_i) cs_n_o <= 1'b0; // every frame opens with a select fall
    for (int i = 0; i < nbits; i++) begin
      b = (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : 1'b0;
      @(posedge clk_i) begin
        sclk_o <= 1'b0;
        din_o <= b; // msb first, set up on the falling edge
      end
      half_wait();
      if (i == pause_bit) begin
        pause_hold(b);
      end
      @(posedge clk_i) sclk_o <= 1'b1;
      rx = {rx[6:0], line};
      if (i % 8 == 7) begin
        rx_q.push_back(rx);
      end
      half_wait();
    end
    @(posedge clk_i) begin
      sclk_o <= cpol; // park at the idle level of the mode
      din_o <= ~din_o;
    end
    half_wait();
    @(posedge clk_i) cs_n_o <= 1'b1;
    half_wait();
  endtask
endmodule

// File: test/serial_flash_spi_front_end_bench.sv
// self-checking bench of the serial flash front end
`timescale 1ns/1ps
`include "sfspi_defines.svh"
// ==========================================
// bench
module serial_flash_spi_front_end_bench;
  localparam int TIMEOUT = 100000;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o, hresp_o, sclk, cs_n, hold_n, wp_n, din, sout, soe, standby;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2 clk_i = ~clk_i;
  sfspi_top #(.WRSR_NS(40)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_hold_n_i(hold_n), .spi_wp_n_i(wp_n), .serial_in_line_i(din), .serial_out_line_o(sout),
    .serial_out_line_oe_o(soe), .standby_o(standby));
  sfspi_master_model i_master (.clk_i(clk_i), .serial_out_line_i(sout), .serial_out_line_oe_i(soe),
    .sclk_o(sclk), .cs_n_o(cs_n), .hold_n_o(hold_n), .wp_n_o(wp_n), .din_o(din));
  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [31:0] sr(input logic [2:0] bp, input logic write_enable_latch, input logic wip);
    return {24'h0, 3'h0, bp, write_enable_latch, wip};
  endfunction
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i) begin
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      htrans_i <= 2'h2;
      hwrite_i <= wr;
    end
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    hsel_i <= 1'b0;
  endtask
  task automatic rdsr(output logic [31:0] s);
    i_master.frame('{`SFSPI_OP_RDSR, 8'h00}, 16);
    s = {24'h0, i_master.rx_q[1]};
  endtask
  // poll busy; the bench timeout ends a stuck cycle
  task automatic wait_idle(output logic [31:0] s);
    s = 32'h1;
    for (int k = 0; k < 150 && s[0] !== 1'b0; k++) rdsr(s);
  endtask
  task automatic write_sr(input logic [7:0] v, output logic [31:0] s);
    i_master.frame('{`SFSPI_OP_WREN}, 8);
    i_master.frame('{`SFSPI_OP_WRSR, v}, 16);
    wait_idle(s);
  endtask
  task automatic set_mode(input logic pol);
    i_master.cpol = pol;
    @(posedge clk_i) i_master.sclk_o <= pol;
    repeat (20) @(posedge clk_i);
  endtask
  initial begin
    logic [31:0] rd, s;
    logic [23:0] a;
    logic [2:0] bp;
    logic [7:0] d[4];
    void'($urandom(35785));
    bp = 3'($urandom_range(7, 1));
    a = {2'h0, 6'($urandom_range(63, 0)), 8'($urandom_range(254, 0)), 8'hFE};
    foreach (d[k]) d[k] = 8'($urandom);
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ahb(1'b0, `SFSPI_CTRL_OFS, 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    ahb(1'b0, `SFSPI_STAT_OFS, 32'h0, rd);
    chk("seen_fall", 32'h0, {31'h0, rd[11]});
    chk("standby_idle", 32'h1, {31'h0, standby});
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF, rd);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    i_master.frame('{`SFSPI_OP_WREN}, 8);
    rdsr(s);
    chk("wel_set", sr(3'h0, 1'b1, 1'b0), s);
    i_master.frame('{`SFSPI_OP_WRDI}, 8);
    rdsr(s);
    chk("wel_clear", sr(3'h0, 1'b0, 1'b0), s);
    i_master.frame('{`SFSPI_OP_WREN}, 7);
    rdsr(s);
    chk("partial_byte", sr(3'h0, 1'b0, 1'b0), s);
    ahb(1'b0, `SFSPI_EVT_OFS, 32'h0, rd);
    chk("event", {16'h0, 8'h01, `SFSPI_OP_RDSR}, {16'h0, rd[15:0]});
    ahb(1'b0, `SFSPI_STAT_OFS, 32'h0, rd);
    chk("seen_fall", 32'h1, {31'h0, rd[11]});
    write_sr({3'h0, bp, 2'h0}, s);
    chk("bp_set", sr(bp, 1'b0, 1'b0), s);
    i_master.frame('{`SFSPI_OP_WREN}, 8);
    i_master.frame('{`SFSPI_OP_BE}, 8);
    rdsr(s);
    chk("bulk_refused", 32'h0, {31'h0, s[0]});
    @(posedge clk_i) i_master.wp_n_o <= 1'b0;
    write_sr(8'h00, s);
    chk("bp_frozen", sr(bp, 1'b0, 1'b0), s);
    @(posedge clk_i) i_master.wp_n_o <= 1'b1;
    write_sr(8'h00, s);
    chk("bp_clear", sr(3'h0, 1'b0, 1'b0), s);
    set_mode(1'b1);
    i_master.frame('{`SFSPI_OP_WREN}, 8);
    i_master.frame('{`SFSPI_OP_SE, a[23:16], a[15:8], a[7:0]}, 32);
    repeat (10) @(posedge clk_i);
    chk("active_in_cycle", 32'h0, {31'h0, standby});
    i_master.pause_bit = 10;
    rdsr(s);
    i_master.pause_bit = -1;
    chk("pause_busy", 32'h1, {31'h0, s[0]});
    wait_idle(s);
    chk("erase_done", 32'h0, s);
    repeat (10) @(posedge clk_i);
    chk("standby_after", 32'h1, {31'h0, standby});
    i_master.frame('{`SFSPI_OP_WREN}, 8);
    i_master.frame('{`SFSPI_OP_PP, a[23:16], a[15:8], a[7:0], d[0], d[1], d[2], d[3]}, 64);
    wait_idle(s);
    // read runs on into the next, still erased, page
    i_master.frame('{`SFSPI_OP_READ, a[23:16], a[15:8], a[7:0], 8'h0, 8'h0, 8'h0, 8'h0}, 64);
    for (int k = 0; k < 4; k++) chk("read_on", {24'h0, (k < 2) ? d[k] : 8'hFF}, {24'h0, i_master.rx_q[4 + k]});
    i_master.frame('{`SFSPI_OP_READ, a[23:16], a[15:8], 8'h00, 8'h0, 8'h0}, 48);
    for (int k = 0; k < 2; k++) chk("page_wrap", {24'h0, d[k + 2]}, {24'h0, i_master.rx_q[4 + k]});
    set_mode(1'b0);
    i_master.frame('{`SFSPI_OP_WREN}, 8);
    i_master.pause_bit = 10;
    rdsr(s);
    i_master.pause_bit = -1;
    chk("pause_resume", sr(3'h0, 1'b1, 1'b0), s);
    tally_and_finish();
  end
endmodule
